// ---- glmrc_top.sv ----
// load model selection, reserve handling and relaxation control
//
// Overview of operation
// R1: load mode picks current or power model
// R2: current sel 0 previous, 1 present average
// R3: current sel 2..6 filtered, lowpass, C/5, host, user
// R4: power sel 0 previous, 1 present average
// R5: power sel 2..6 I*V, lowpass*V, E/5, host, user
// R6: host writes energy scale 1 or 10 only
// R7: scale 10 means centi energy and power units
// R8: reserve kept after remaining reaches zero
// R9: reserve compensation select chooses loaded or no-load
// R10: discharge flow when magnitude exceeds discharge threshold
// R11: charge flow when magnitude exceeds charge threshold
// R12: relax after low current for discharge time
// R13: relax after low current for charge time
// R14: open-circuit readings after six minutes relaxed
// R15: capacity learning only when slew below four
// R16: quit relax after high current quit time
// R17: capacity starts at initial, replaced by learned
// R18: timers restart when their condition breaks
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module glmrc_top
  import glmrc_pkg::*;
#(
  parameter int unsigned SEC_CYC = glmrc_pkg::SEC_CYCLES
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [glmrc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [glmrc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [glmrc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic signed [15:0] filtered_current,
  input wire logic [15:0] cell_voltage,
  input wire logic [15:0] avg_prev_current,
  input wire logic [15:0] avg_now_current,
  input wire logic [15:0] avg_prev_power,
  input wire logic [15:0] avg_now_power,
  input wire logic [15:0] voltage_slew,
  input wire logic [15:0] learned_qmax,
  input wire logic learned_qmax_valid,
  input wire logic [15:0] reserve_loaded,
  input wire logic [15:0] reserve_noload,
  input wire logic remaining_zero,
  input wire logic terminate_reached,
  output logic load_mode_flag,
  output logic [31:0] rate_value,
  output logic energy_centi,
  output logic dsg_flow,
  output logic chg_flow,
  output logic relax_mode,
  output logic ocv_sample_en,
  output logic qmax_update_en,
  output logic [15:0] max_chemical_capacity,
  output logic [15:0] reserve_value,
  output logic reserve_hold
);
  import glmrc_pkg::*;

  // magnitude of a signed current sample
  function automatic logic [15:0] mag16(input logic signed [15:0] v);
    mag16 = v[15] ? 16'(-v) : 16'(v);
  endfunction

  logic rst_s1_reg;
  logic rst_n;
  logic cfg_ld_reg;
  logic cfg_rc_reg;
  logic [2:0] cfg_sel_reg;
  logic [15:0] escale_reg;
  logic [15:0] dsg_thr_reg;
  logic [15:0] chg_thr_reg;
  logic [15:0] rlx_thr_reg;
  logic [15:0] dsg_t_reg;
  logic [15:0] chg_t_reg;
  logic [15:0] quit_t_reg;
  logic [15:0] user_cur_reg;
  logic [15:0] user_pwr_reg;
  logic [15:0] des_cap_reg;
  logic [15:0] des_en_reg;
  logic [15:0] host_rate_reg;
  logic [15:0] qmax_reg;
  logic [31:0] sec_cnt_reg;
  logic sec_tick_reg;
  logic [31:0] lp_reg;
  logic [8:0] ocv_cnt_reg;
  glmrc_state_type state_reg;
  glmrc_state_type state_next;
  logic [15:0] i_mag;
  logic low_i;
  logic high_i;
  logic dsg_rlx_done;
  logic chg_rlx_done;
  logic quit_done;
  logic [31:0] rate_next;
  logic [31:0] pwr_div;
  logic [15:0] status_word;

  // reset release through two flip-flops
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  // configuration register writes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ld_reg <= 1'b0;
      cfg_rc_reg <= 1'b0;
      cfg_sel_reg <= RST_SEL;
      escale_reg <= RST_ESCALE;
      dsg_thr_reg <= RST_THR;
      chg_thr_reg <= RST_THR;
      rlx_thr_reg <= RST_THR;
      dsg_t_reg <= RST_TIME;
      chg_t_reg <= RST_TIME;
      quit_t_reg <= RST_TIME;
      user_cur_reg <= RST_VAL;
      user_pwr_reg <= RST_VAL;
      des_cap_reg <= RST_VAL;
      des_en_reg <= RST_VAL;
      host_rate_reg <= RST_VAL;
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_CFG: begin
          cfg_ld_reg <= reg_wdata[CFG_LDMODE_BIT];
          cfg_rc_reg <= reg_wdata[CFG_RESCOMP_BIT];
          cfg_sel_reg <= reg_wdata[CFG_SEL_LSB +: 3];
        end
        OFS_ESCALE: begin
          // only the two legal scales are stored
          if (reg_wdata == ESCALE_ONE || reg_wdata == ESCALE_TEN) begin
            escale_reg <= reg_wdata; // R6
          end
        end
        OFS_DSG_THR: dsg_thr_reg <= reg_wdata;
        OFS_CHG_THR: chg_thr_reg <= reg_wdata;
        OFS_RLX_THR: rlx_thr_reg <= reg_wdata;
        OFS_DSG_RLX_T: dsg_t_reg <= reg_wdata;
        OFS_CHG_RLX_T: chg_t_reg <= reg_wdata;
        OFS_QUIT_RLX_T: quit_t_reg <= reg_wdata;
        OFS_USER_CUR: user_cur_reg <= reg_wdata;
        OFS_USER_PWR: user_pwr_reg <= reg_wdata;
        OFS_DES_CAP: des_cap_reg <= reg_wdata;
        OFS_DES_ENERGY: des_en_reg <= reg_wdata;
        OFS_HOST_RATE: host_rate_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  // chemical capacity: initial value, then learned updates
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      qmax_reg <= RST_VAL;
    end else begin
      if (reg_wr && reg_addr == OFS_QMAX_INIT) begin
        qmax_reg <= reg_wdata; // R17
      end else if (learned_qmax_valid && qmax_update_en) begin
        qmax_reg <= learned_qmax; // R15 R17
      end
    end
  end

  // one-second tick for all timers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_cnt_reg <= 32'h0000_0000;
      sec_tick_reg <= 1'b0;
    end else if (sec_cnt_reg >= 32'(SEC_CYC - 1)) begin
      sec_cnt_reg <= 32'h0000_0000;
      sec_tick_reg <= 1'b1;
    end else begin
      sec_cnt_reg <= sec_cnt_reg + 32'h0000_0001;
      sec_tick_reg <= 1'b0;
    end
  end

  // low-pass of filtered current magnitude, tau in seconds
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lp_reg <= 32'h0000_0000;
    end else if (sec_tick_reg) begin
      lp_reg <= lp_reg + 32'(signed'({1'b0, i_mag, 8'h00} - {1'b0, lp_reg})
        / signed'(LP_TAU_S)); // R3
    end
  end

  assign i_mag = mag16(filtered_current);
  assign low_i = i_mag < rlx_thr_reg;
  assign high_i = i_mag > rlx_thr_reg;

  // relax entry and exit qualification timers
  glmrc_timer u_dsg_rlx (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sec_tick(sec_tick_reg),
    .cond(low_i),
    .limit(dsg_t_reg),
    .done(dsg_rlx_done)
  );
  glmrc_timer u_chg_rlx (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sec_tick(sec_tick_reg),
    .cond(low_i),
    .limit(chg_t_reg),
    .done(chg_rlx_done)
  );
  glmrc_timer u_quit (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sec_tick(sec_tick_reg),
    .cond(high_i),
    .limit(quit_t_reg),
    .done(quit_done)
  );

  // relaxation state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_ACTIVE: begin
        if (dsg_rlx_done || chg_rlx_done) begin
          state_next = ST_RELAX; // R12 R13
        end
      end
      ST_RELAX: begin
        if (quit_done) begin
          state_next = ST_ACTIVE; // R16
        end
      end
      default: state_next = ST_ACTIVE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_ACTIVE;
    end else begin
      state_reg <= state_next;
    end
  end

  // seconds spent relaxed, saturating at the open-circuit wait
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ocv_cnt_reg <= 9'h000;
    end else if (state_reg != ST_RELAX) begin
      ocv_cnt_reg <= 9'h000;
    end else if (sec_tick_reg && ocv_cnt_reg < 9'(OCV_WAIT_S)) begin
      ocv_cnt_reg <= ocv_cnt_reg + 9'h001; // R14
    end
  end

  // power units follow the energy scale
  assign pwr_div = (escale_reg == ESCALE_TEN) ? CENTI_DIV : MILLI_DIV; // R7

  // rate source selection per load mode
  always_comb begin
    rate_next = 32'h0000_0000;
    if (!cfg_ld_reg) begin
      case (cfg_sel_reg)
        SEL_PREV_AVG: rate_next = {16'h0000, avg_prev_current}; // R2
        SEL_NOW_AVG: rate_next = {16'h0000, avg_now_current}; // R2
        SEL_FILT: rate_next = {16'h0000, i_mag}; // R3
        SEL_LOWPASS: rate_next = {8'h00, lp_reg[31:8]}; // R3
        SEL_DESIGN5: rate_next = {16'h0000, des_cap_reg} / C5_DIV; // R3
        SEL_HOST: rate_next = {16'h0000, host_rate_reg}; // R3
        SEL_USER: rate_next = {16'h0000, user_cur_reg}; // R3
        default: rate_next = {16'h0000, avg_now_current};
      endcase
    end else begin
      case (cfg_sel_reg)
        SEL_PREV_AVG: rate_next = {16'h0000, avg_prev_power}; // R4
        SEL_NOW_AVG: rate_next = {16'h0000, avg_now_power}; // R4
        SEL_FILT: rate_next = (i_mag * cell_voltage) / pwr_div; // R5
        SEL_LOWPASS: rate_next = (lp_reg[23:8] * cell_voltage) / pwr_div; // R5
        SEL_DESIGN5: rate_next = {16'h0000, des_en_reg} / C5_DIV; // R5
        SEL_HOST: rate_next = {16'h0000, host_rate_reg}; // R5
        SEL_USER: rate_next = {16'h0000, user_pwr_reg}; // R5 R7
        default: rate_next = {16'h0000, avg_now_power};
      endcase
    end
  end

  // registered model outputs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      load_mode_flag <= 1'b0;
      rate_value <= 32'h0000_0000;
      energy_centi <= 1'b0;
    end else begin
      load_mode_flag <= cfg_ld_reg; // R1
      rate_value <= rate_next; // R1
      energy_centi <= escale_reg == ESCALE_TEN; // R7
    end
  end

  // flow detection and relax-derived outputs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dsg_flow <= 1'b0;
      chg_flow <= 1'b0;
      relax_mode <= 1'b0;
      ocv_sample_en <= 1'b0;
      qmax_update_en <= 1'b0;
      max_chemical_capacity <= RST_VAL;
    end else begin
      dsg_flow <= filtered_current[15] && i_mag > dsg_thr_reg; // R10
      chg_flow <= !filtered_current[15] && i_mag > chg_thr_reg; // R11
      // same state copy as the open-circuit and update enables
      relax_mode <= state_reg == ST_RELAX;
      ocv_sample_en <= state_reg == ST_RELAX
        && ocv_cnt_reg >= 9'(OCV_WAIT_S); // R14
      qmax_update_en <= state_reg == ST_RELAX
        && ocv_cnt_reg >= 9'(OCV_WAIT_S)
        && voltage_slew < DVDT_LIMIT_UV; // R15
      max_chemical_capacity <= qmax_reg; // R17
    end
  end

  // reserve selection and hold window
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reserve_value <= RST_VAL;
      reserve_hold <= 1'b0;
    end else begin
      reserve_value <= cfg_rc_reg ? reserve_noload : reserve_loaded; // R9
      reserve_hold <= remaining_zero && !terminate_reached; // R8
    end
  end

  assign status_word = {8'h00, reserve_hold, energy_centi, chg_flow,
    dsg_flow, qmax_update_en, ocv_sample_en, relax_mode, load_mode_flag};

  // read data one cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_CFG: reg_rdata <= {11'h000, cfg_sel_reg, cfg_rc_reg, cfg_ld_reg};
        OFS_ESCALE: reg_rdata <= escale_reg;
        OFS_DSG_THR: reg_rdata <= dsg_thr_reg;
        OFS_CHG_THR: reg_rdata <= chg_thr_reg;
        OFS_RLX_THR: reg_rdata <= rlx_thr_reg;
        OFS_DSG_RLX_T: reg_rdata <= dsg_t_reg;
        OFS_CHG_RLX_T: reg_rdata <= chg_t_reg;
        OFS_QUIT_RLX_T: reg_rdata <= quit_t_reg;
        OFS_USER_CUR: reg_rdata <= user_cur_reg;
        OFS_USER_PWR: reg_rdata <= user_pwr_reg;
        OFS_DES_CAP: reg_rdata <= des_cap_reg;
        OFS_DES_ENERGY: reg_rdata <= des_en_reg;
        OFS_HOST_RATE: reg_rdata <= host_rate_reg;
        OFS_QMAX_INIT: reg_rdata <= qmax_reg;
        OFS_STATUS: reg_rdata <= status_word;
        OFS_RATE_LO: reg_rdata <= rate_value[15:0];
        OFS_RATE_HI: reg_rdata <= rate_value[31:16];
        OFS_QMAX: reg_rdata <= max_chemical_capacity;
        OFS_RESERVE: reg_rdata <= reserve_value;
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // checks on the design's own behaviour
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_ldmode;
    ##1 load_mode_flag == $past(cfg_ld_reg);
  endproperty
  a_ldmode: assert property (p_ldmode) // R1
    else $error("load mode flag mismatch");

  property p_cc_user;
    (!cfg_ld_reg && cfg_sel_reg == SEL_USER)
      |=> rate_value == $past({16'h0000, user_cur_reg});
  endproperty
  a_cc_user: assert property (p_cc_user) // R3
    else $error("user current rate not used");

  property p_cc_now;
    (!cfg_ld_reg && cfg_sel_reg == SEL_NOW_AVG)
      |=> rate_value == $past({16'h0000, avg_now_current});
  endproperty
  a_cc_now: assert property (p_cc_now) // R2
    else $error("present average not used");

  property p_cp_prev;
    (cfg_ld_reg && cfg_sel_reg == SEL_PREV_AVG)
      |=> rate_value == $past({16'h0000, avg_prev_power});
  endproperty
  a_cp_prev: assert property (p_cp_prev) // R4
    else $error("previous power not used");

  property p_escale;
    escale_reg == ESCALE_ONE || escale_reg == ESCALE_TEN;
  endproperty
  a_escale: assert property (p_escale) // R6
    else $error("illegal energy scale");

  property p_dsg;
    ##1 dsg_flow == $past(filtered_current[15]
      && mag16(filtered_current) > dsg_thr_reg);
  endproperty
  a_dsg: assert property (p_dsg) // R10
    else $error("discharge flow wrong");

  property p_chg;
    (!filtered_current[15] && mag16(filtered_current) <= chg_thr_reg)
      |=> !chg_flow;
  endproperty
  a_chg: assert property (p_chg) // R11
    else $error("charge flow without current");

  property p_resv;
    (cfg_rc_reg && !reg_wr) |=> reserve_value == $past(reserve_noload);
  endproperty
  a_resv: assert property (p_resv) // R9
    else $error("reserve compensation wrong");

  property p_qupd;
    qmax_update_en |-> relax_mode && ocv_sample_en;
  endproperty
  a_qupd: assert property (p_qupd) // R15
    else $error("capacity update outside relax");

  property p_ocv;
    (state_reg != ST_RELAX) |=> !ocv_sample_en;
  endproperty
  a_ocv: assert property (p_ocv) // R14
    else $error("open-circuit reading outside relax");

  property p_quit;
    (state_reg == ST_RELAX && !quit_done) |=> state_reg == ST_RELAX;
  endproperty
  a_quit: assert property (p_quit) // R16
    else $error("relax left early");

  c_relax: cover property (state_reg == ST_ACTIVE ##1 state_reg == ST_RELAX);
  c_exit: cover property (state_reg == ST_RELAX ##1 state_reg == ST_ACTIVE);
  c_qupd: cover property (qmax_update_en && learned_qmax_valid);
  c_cp: cover property (cfg_ld_reg && cfg_sel_reg == SEL_FILT);
endmodule
`default_nettype wire

// ---- glmrc_pkg.sv ----
// constants shared by the load model and relaxation control block
package glmrc_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned SEC_S = 1;
  localparam int unsigned SEC_CYCLES = CLK_HZ * SEC_S;
  localparam int unsigned OCV_WAIT_S = 360;
  localparam int unsigned LP_TAU_S = 14;
  localparam logic [15:0] DVDT_LIMIT_UV = 16'h0004;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;
  // register offsets (word index)
  localparam logic [4:0] OFS_CFG = 5'h00;
  localparam logic [4:0] OFS_ESCALE = 5'h01;
  localparam logic [4:0] OFS_DSG_THR = 5'h02;
  localparam logic [4:0] OFS_CHG_THR = 5'h03;
  localparam logic [4:0] OFS_RLX_THR = 5'h04;
  localparam logic [4:0] OFS_DSG_RLX_T = 5'h05;
  localparam logic [4:0] OFS_CHG_RLX_T = 5'h06;
  localparam logic [4:0] OFS_QUIT_RLX_T = 5'h07;
  localparam logic [4:0] OFS_USER_CUR = 5'h08;
  localparam logic [4:0] OFS_USER_PWR = 5'h09;
  localparam logic [4:0] OFS_DES_CAP = 5'h0A;
  localparam logic [4:0] OFS_DES_ENERGY = 5'h0B;
  localparam logic [4:0] OFS_HOST_RATE = 5'h0C;
  localparam logic [4:0] OFS_QMAX_INIT = 5'h0D;
  localparam logic [4:0] OFS_STATUS = 5'h0E;
  localparam logic [4:0] OFS_RATE_LO = 5'h0F;
  localparam logic [4:0] OFS_RATE_HI = 5'h10;
  localparam logic [4:0] OFS_QMAX = 5'h11;
  localparam logic [4:0] OFS_RESERVE = 5'h12;
  // cfg field positions
  localparam int unsigned CFG_LDMODE_BIT = 0;
  localparam int unsigned CFG_RESCOMP_BIT = 1;
  localparam int unsigned CFG_SEL_LSB = 2;
  // status field positions
  localparam int unsigned ST_LDMODE_BIT = 0;
  localparam int unsigned ST_RELAX_BIT = 1;
  localparam int unsigned ST_OCV_BIT = 2;
  localparam int unsigned ST_QUPD_BIT = 3;
  localparam int unsigned ST_DSG_BIT = 4;
  localparam int unsigned ST_CHG_BIT = 5;
  localparam int unsigned ST_CENTI_BIT = 6;
  localparam int unsigned ST_RSV_BIT = 7;
  // reset values
  localparam logic [2:0] RST_SEL = 3'h1;
  localparam logic [15:0] RST_ESCALE = 16'h0001;
  localparam logic [15:0] RST_THR = 16'h0000;
  localparam logic [15:0] RST_TIME = 16'h0000;
  localparam logic [15:0] RST_VAL = 16'h0000;
  // legal energy scales and unit divisors
  localparam logic [15:0] ESCALE_ONE = 16'h0001;
  localparam logic [15:0] ESCALE_TEN = 16'h000A;
  localparam logic [31:0] MILLI_DIV = 32'h0000_03E8;
  localparam logic [31:0] CENTI_DIV = 32'h0000_2710;
  localparam logic [31:0] C5_DIV = 32'h0000_0005;
  typedef enum logic [2:0] {
    SEL_PREV_AVG = 3'h0,
    SEL_NOW_AVG = 3'h1,
    SEL_FILT = 3'h2,
    SEL_LOWPASS = 3'h3,
    SEL_DESIGN5 = 3'h4,
    SEL_HOST = 3'h5,
    SEL_USER = 3'h6
  } glmrc_sel_type;
  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b01,
    ST_RELAX = 2'b10
  } glmrc_state_type;
endpackage

// ---- glmrc_timer.sv ----
// qualifying timer: counts seconds while a condition holds
`timescale 1ns/1ps
`default_nettype none
module glmrc_timer (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sec_tick,
  input wire logic cond,
  input wire logic [15:0] limit,
  output logic done
);
  logic [15:0] count_reg;
  // count restarts whenever the condition drops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 16'h0000;
    end else if (!cond) begin
      count_reg <= 16'h0000; // R18
    end else if (sec_tick && count_reg != 16'hFFFF) begin
      count_reg <= count_reg + 16'h0001;
    end
  end
  // qualified once the full time has been spent in the condition
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else begin
      done <= cond && (count_reg >= limit); // R18
    end
  end
endmodule
`default_nettype wire

// ---- glmrc_bench.sv ----
// self-checking bench for the load model and relaxation control block
`timescale 1ns/1ps
`default_nettype none
module glmrc_bench;
  import glmrc_pkg::*;
  // one simulated second is ten clock cycles
  localparam int unsigned SC = 10;
  logic core_clk, arst_n, reg_wr, reg_rd, lq_v, rz, term;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, cv, apc, anc, app, anp, slew, lq;
  logic [15:0] rl, rn, mcc, rsv, dcap, deng, hrate, ucur, upwr, mag;
  logic signed [15:0] fc;
  logic [31:0] rate;
  logic lmf, ecenti, dsg, chg, rlx, ocv, qupd, rhold;
  int bad_count, cmp_count;
  // current, expected {dsg, chg} with discharge 100 and charge 50
  logic [17:0] ftab [6] = '{{16'hFF9B, 2'b10}, {16'hFF9C, 2'b00},
    {16'h0033, 2'b01}, {16'h0032, 2'b00}, {16'h0000, 2'b00},
    {16'hFF38, 2'b10}};

  glmrc_top #(.SEC_CYC(SC)) i_dut (.core_clk(core_clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .filtered_current(fc),
    .cell_voltage(cv), .avg_prev_current(apc), .avg_now_current(anc),
    .avg_prev_power(app), .avg_now_power(anp), .voltage_slew(slew),
    .learned_qmax(lq), .learned_qmax_valid(lq_v), .reserve_loaded(rl),
    .reserve_noload(rn), .remaining_zero(rz), .terminate_reached(term),
    .load_mode_flag(lmf), .rate_value(rate), .energy_centi(ecenti),
    .dsg_flow(dsg), .chg_flow(chg), .relax_mode(rlx),
    .ocv_sample_en(ocv), .qmax_update_en(qupd),
    .max_chemical_capacity(mcc), .reserve_value(rsv),
    .reserve_hold(rhold));

  // 25 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // cycle waits; settle ends mid-cycle where outputs are stable
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // register bus master: one-cycle strobes
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk({16'h0000, reg_rdata}, {16'h0000, e});
  endtask

  // expected rate for a load mode, selection and energy scale
  function automatic logic [31:0] exp_rate(input logic pw,
      input logic [2:0] s, input logic ten);
    logic [31:0] m;
    m = {16'h0000, (fc < 0) ? 16'(-fc) : 16'(fc)};
    case (s)
      3'h0: return {16'h0000, pw ? app : apc};
      3'h2: return pw ? m * {16'h0000, cv} / (ten ? CENTI_DIV : MILLI_DIV)
                      : m;
      3'h4: return {16'h0000, pw ? deng : dcap} / C5_DIV;
      3'h5: return {16'h0000, hrate};
      3'h6: return {16'h0000, pw ? upwr : ucur};
      default: return {16'h0000, pw ? anp : anc};
    endcase
  endfunction

  // closing report and verdict
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    cyc(20000);
    bad_count++;
    summarize();
  end

  // main sequence
  initial begin
    {arst_n, reg_wr, reg_rd, lq_v, rz, term} = 6'h00;
    {reg_addr, reg_wdata, cv, apc, anc, app, anp} = '0;
    {slew, lq, rl, rn, fc, mag} = '0;
    void'($urandom(59704));
    cyc(5);
    arst_n <= 1'b1;
    cyc(3);
    rd(OFS_CFG, 16'h0004);
    rd(OFS_ESCALE, 16'h0001);
    rd(OFS_STATUS, 16'h0000);
    rd(5'h1F, 16'h0000);
    wr(OFS_QMAX_INIT, 16'h1234);
    settle(2);
    chk({16'h0000, mcc}, 32'h0000_1234);
    rd(OFS_QMAX, 16'h1234);
    wr(OFS_CFG, 16'h000C);
    settle(3);
    chk(rate, 32'h0000_0000);
    wr(OFS_CFG, 16'h000D);
    settle(3);
    chk(rate, 32'h0000_0000);
    $display("reset and init test done");
    // every selection except lowpass in both modes under both energy scales
    for (int t = 0; t < 2; t++) begin
      wr(OFS_ESCALE, t ? ESCALE_TEN : ESCALE_ONE);
      wr(OFS_ESCALE, 16'h0005);
      rd(OFS_ESCALE, t ? ESCALE_TEN : ESCALE_ONE);
      for (int m = 0; m < 2; m++) begin
        for (int s = 0; s < 8; s++) begin
          if (s == 3)
            continue;
          @(posedge core_clk);
          mag = 16'($urandom_range(30000, 1));
          fc <= m ? -mag : mag;
          {apc, anc} <= $urandom;
          {app, anp} <= $urandom;
          cv <= 16'($urandom);
          {dcap, deng} = $urandom;
          {hrate, ucur} = $urandom;
          upwr = 16'($urandom);
          wr(OFS_DES_CAP, dcap);
          wr(OFS_DES_ENERGY, deng);
          wr(OFS_HOST_RATE, hrate);
          wr(OFS_USER_CUR, ucur);
          wr(OFS_USER_PWR, upwr);
          wr(OFS_CFG, {11'h000, 3'(s), 1'b0, 1'(m)});
          settle(3);
          if (m) chk(rate, exp_rate(1'b1, 3'(s), t[0]));
          else chk(rate, exp_rate(1'b0, 3'(s), t[0]));
          chk({31'h0, lmf}, 32'(m));
          chk({31'h0, ecenti}, 32'(t));
        end
      end
    end
    wr(OFS_ESCALE, ESCALE_ONE);
    $display("rate model test done");
    // flow detection at threshold boundaries
    wr(OFS_DSG_THR, 16'h0064);
    wr(OFS_CHG_THR, 16'h0032);
    foreach (ftab[i]) begin
      @(posedge core_clk);
      fc <= ftab[i][17:2];
      settle(3);
      chk({30'h0, dsg, chg}, {30'h0, ftab[i][1:0]});
    end
    $display("flow threshold test done");
    // reserve compensation select and hold window
    for (int i = 0; i < 8; i++) begin
      wr(OFS_CFG, {11'h000, 3'h1, i[2], 1'b0});
      rz <= i[1];
      term <= i[0];
      rl <= 16'($urandom);
      rn <= 16'($urandom);
      settle(3);
      chk({16'h0000, rsv}, {16'h0000, i[2] ? rn : rl});
      chk({31'h0, rhold}, {31'h0, i[1] & ~i[0]});
    end
    $display("reserve test done");
    // relax entry with a broken qualifying interval
    wr(OFS_RLX_THR, 16'h0064);
    wr(OFS_DSG_RLX_T, 16'h0003);
    wr(OFS_CHG_RLX_T, 16'h00FF);
    wr(OFS_QUIT_RLX_T, 16'h0002);
    fc <= 16'sd500;
    slew <= 16'h0003;
    cyc(30);
    fc <= 16'sd10;
    cyc(15);
    fc <= 16'sd500;
    cyc(5);
    fc <= 16'sd10;
    settle(15);
    chk({31'h0, rlx}, 32'h0);
    settle(45);
    chk({31'h0, rlx}, 32'h1);
    settle(3400);
    chk({31'h0, ocv}, 32'h0);
    settle(300);
    chk({30'h0, ocv, qupd}, 32'h3);
    rd(OFS_STATUS, 16'h000E);
    @(posedge core_clk);
    lq <= 16'h2222;
    lq_v <= 1'b1;
    @(posedge core_clk);
    lq_v <= 1'b0;
    settle(3);
    chk({16'h0000, mcc}, 32'h0000_2222);
    @(posedge core_clk);
    slew <= 16'h0004;
    settle(3);
    chk({31'h0, qupd}, 32'h0);
    $display("relax entry test done");
    // relax exit after the quit time, then entry on the charge time
    @(posedge core_clk);
    fc <= 16'sd500;
    settle(8);
    chk({31'h0, rlx}, 32'h1);
    settle(30);
    chk({30'h0, rlx, ocv}, 32'h0);
    wr(OFS_DSG_RLX_T, 16'hFFFF);
    wr(OFS_CHG_RLX_T, 16'h0003);
    fc <= -16'sd20;
    settle(60);
    chk({31'h0, rlx}, 32'h1);
    $display("relax exit test done");
    summarize();
  end
endmodule
`default_nettype wire
